// >>> ist_bus_peer.sv
// Far side of the two-wire bus: pull-up resistors and one foreign master.
// Assumes the device's pin enables come in; the wire levels are resolved here.
`timescale 1ns/10ps
`default_nettype none
module ist_bus_peer (
   // Device pin enables.
   input  wire logic dev_sda_oe_in,
   input  wire logic dev_scl_oe_in,
   // Resolved wire levels.
   output logic      sda_out,
   output logic      scl_out
);
   logic sda_pull_r = 1'h0; // High while the foreign master pulls data low.
   logic scl_pull_r = 1'h0; // High while the foreign master pulls clock low.
   // Open drain with pull-up, so any enable wins over the resistor.
   assign sda_out = !(dev_sda_oe_in || sda_pull_r);
   assign scl_out = !(dev_scl_oe_in || scl_pull_r);
   // Start, eight 125 ns clocks, stop; the clock stands high between frames.
   task automatic frame();
      sda_pull_r = 1'h1;
      #62.5;
      repeat (8) begin
         scl_pull_r = 1'h1;
         #62.5;
         scl_pull_r = 1'h0;
         #62.5;
      end
      sda_pull_r = 1'h0;
   endtask
endmodule
`default_nettype wire

// >>> ist_pkg.sv
// Constants shared by the start-condition trigger block.
// Assumes a 250 MHz core clock; the bus pins are open drain and pulled up outside.
package ist_pkg;
   // Core clock period in picoseconds.
   localparam int unsigned CLK_PERIOD_PS = 4000;
   // Start hold time in nanoseconds, standard mode figure.
   localparam int unsigned START_HOLD_NS = 4000;
   // Least hold count, rounded up to whole cycles.
   localparam int unsigned START_HOLD_CYC = (START_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   // Bus free time before a start in nanoseconds.
   localparam int unsigned BUS_FREE_NS = 4700;
   // Least bus free count in cycles.
   localparam int unsigned BUS_FREE_CYC = (BUS_FREE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   // Width of the timing counter.
   localparam int unsigned CNT_W = 13;
   // Reset value of the trigger bit.
   localparam logic RST_TRIGGER = 1'h0;
   // Controller states, Gray coded along the start path.
   typedef enum logic [1:0] {
      IST_IDLE = 2'h0,
      IST_FREE = 2'h1,
      IST_HOLD = 2'h3,
      IST_MAST = 2'h2
   } ist_state_t;
endpackage

// >>> ist_start_trigger.sv
// Start-condition trigger logic of an on-chip two-wire bus controller.
// Assumes open-drain pins resolved outside and software that keeps its timing windows.
// Limitation: only the start half lives here; stop generation is elsewhere.
//
// Notes on behaviour
// - No start while trigger is zero.
// - Free bus: become master, data falls, clock high.
// - Hold start for hold time before clock low.
// - Busy bus: keep trigger as pending request.
// - Pending request starts once bus is released.
// - Cleared by write, lost arbitration, start, reset.
// - Interface disabled makes trigger invalid.
`timescale 1ns/10ps
`default_nettype none
module ist_start_trigger #(
   // Start hold time in core cycles.
   parameter int unsigned HOLD_CYC = ist_pkg::START_HOLD_CYC,
   // Bus free time in core cycles.
   parameter int unsigned FREE_CYC = ist_pkg::BUS_FREE_CYC
) (
   // Clock and reset.
   input  wire logic core_clk_in,
   input  wire logic rstn_in,
   // Control bits written by software.
   input  wire logic start_trigger_wr_in,
   input  wire logic start_trigger_val_in,
   input  wire logic bus_interface_enable_in,
   // Events from the rest of the controller.
   input  wire logic arb_lost_in,
   input  wire logic master_release_in,
   // Serial data line pin, open drain.
   input  wire logic serial_data_line_in,
   output logic      serial_data_line_out,
   output logic      serial_data_line_oe_out,
   // Serial clock line pin, open drain.
   input  wire logic serial_clock_line_in,
   output logic      serial_clock_line_out,
   output logic      serial_clock_line_oe_out,
   // Status.
   output logic      start_trigger_out,
   output logic      bus_busy_out,
   output logic      master_out,
   output logic      start_done_out
);
   // Synchronised pin levels and the previous data line level.
   logic                   sda_s;
   logic                   scl_s;
   logic                   sda_d_r;
   // Bus conditions seen on the lines.
   logic                   start_seen;
   logic                   stop_seen;
   // Controller state and its next value.
   ist_pkg::ist_state_t    state_r;
   ist_pkg::ist_state_t    state_nxt;
   // Timing counter for free time and hold time.
   logic [ist_pkg::CNT_W-1:0] cnt_r;
   // Pulse when start generation completes.
   logic                   start_fin;
   // Trigger valid only with the interface enabled.
   logic                   trig_ok;

   // Pins are from outside the domain, so each passes two flip-flops.
   // Both stages reset high, the idle level of a pulled-up line,
   // so no false edge is seen after reset.
   ist_sync u_sda (
      .core_clk_in (core_clk_in),
      .rstn_in     (rstn_in),
      .async_in    (serial_data_line_in),
      .sync_out    (sda_s)
   );
   ist_sync u_scl (
      .core_clk_in (core_clk_in),
      .rstn_in     (rstn_in),
      .async_in    (serial_clock_line_in),
      .sync_out    (scl_s)
   );

   // Delay the synchronised data line to find its edges.
   always_ff @(posedge core_clk_in) begin
      if (!rstn_in) begin
         sda_d_r <= 1'h1;
      end else begin
         sda_d_r <= sda_s;
      end
   end

   // A start is a data fall with clock high; a stop is a data rise with clock high.
   // Only the second synchroniser stage is read here, never the first.
   assign start_seen = scl_s && sda_d_r && !sda_s;
   assign stop_seen  = scl_s && !sda_d_r && sda_s;
   assign trig_ok    = start_trigger_out && bus_interface_enable_in;

   // Bus busy flag follows start and stop conditions on the lines.
   // With the interface off the bus state is forgotten and relearned from the next start.
   always_ff @(posedge core_clk_in) begin
      if (!rstn_in || !bus_interface_enable_in) begin
         bus_busy_out <= 1'h0;
      end else if (start_seen) begin
         bus_busy_out <= 1'h1;
      end else if (stop_seen) begin
         bus_busy_out <= 1'h0;
      end
   end

   // Trigger bit; clears lose only when software writes a one in the same cycle.
   // A software write is the only way to set it; loss and completion only clear it.
   always_ff @(posedge core_clk_in) begin
      if (!rstn_in) begin
         start_trigger_out <= ist_pkg::RST_TRIGGER;
      end else if (start_trigger_wr_in) begin
         start_trigger_out <= start_trigger_val_in;
      end else if (arb_lost_in || start_fin) begin
         start_trigger_out <= 1'h0;
      end
   end

   // Next state of the start sequence.
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ist_pkg::IST_IDLE: begin
            // A pending request waits here while the bus is busy.
            // With the interface off trig_ok is low, so nothing leaves this state.
            if (trig_ok && !bus_busy_out) begin
               state_nxt = ist_pkg::IST_FREE;
            end
         end
         ist_pkg::IST_FREE: begin
            // Lines must stay high for the free time before the start.
            // A lost arbitration drops the attempt before any line is driven.
            if (!trig_ok || arb_lost_in || bus_busy_out || !sda_s || !scl_s) begin
               state_nxt = ist_pkg::IST_IDLE;
            end else if (cnt_r >= ist_pkg::CNT_W'(FREE_CYC - 1)) begin
               state_nxt = ist_pkg::IST_HOLD;
            end
         end
         ist_pkg::IST_HOLD: begin
            // The enable going low abandons the start before the clock line falls.
            if (arb_lost_in || !bus_interface_enable_in) begin
               state_nxt = ist_pkg::IST_IDLE;
            end else if (cnt_r >= ist_pkg::CNT_W'(HOLD_CYC - 1)) begin
               state_nxt = ist_pkg::IST_MAST;
            end
         end
         ist_pkg::IST_MAST: begin
            // The rest of the controller ends the master role.
            if (master_release_in || arb_lost_in || !bus_interface_enable_in) begin
               state_nxt = ist_pkg::IST_IDLE;
            end
         end
         default: state_nxt = ist_pkg::IST_IDLE;
      endcase
   end

   // State register; disabling the interface abandons any sequence.
   // Trade-off: an abandoned start releases the data line at once, which other
   // masters see as a stop, so software should not disable in mid-transfer.
   always_ff @(posedge core_clk_in) begin
      if (!rstn_in || !bus_interface_enable_in) begin
         state_r <= ist_pkg::IST_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // Counter restarts on every state change.
   // It saturates, so a long wait in one state never wraps into a false match.
   always_ff @(posedge core_clk_in) begin
      if (!rstn_in || state_nxt != state_r) begin
         cnt_r <= '0;
      end else if (cnt_r != '1) begin
         cnt_r <= cnt_r + 1'h1;
      end
   end

   // Completion is the step from hold to master.
   // The same edge clears the trigger unless software writes it then.
   assign start_fin = (state_r == ist_pkg::IST_HOLD) && (state_nxt == ist_pkg::IST_MAST);

   // Pin drive: data low from the start on, clock low once the hold has run.
   // Decoding the next state keeps the pins in step with the state register.
   always_ff @(posedge core_clk_in) begin
      if (!rstn_in) begin
         serial_data_line_oe_out  <= 1'h0;
         serial_clock_line_oe_out <= 1'h0;
      end else begin
         serial_data_line_oe_out  <= (state_nxt == ist_pkg::IST_HOLD) ||
                                     (state_nxt == ist_pkg::IST_MAST);
         serial_clock_line_oe_out <= (state_nxt == ist_pkg::IST_MAST);
      end
   end

   // Open drain: only ever drive low.
   // The levels stay low; the enables alone decide what the lines see.
   always_ff @(posedge core_clk_in) begin
      if (!rstn_in) begin
         serial_data_line_out  <= 1'h0;
         serial_clock_line_out <= 1'h0;
      end else begin
         serial_data_line_out  <= 1'h0;
         serial_clock_line_out <= 1'h0;
      end
   end

   // Master flag and completion pulse.
   // The pulse lasts one cycle and coincides with the clock enable rising.
   always_ff @(posedge core_clk_in) begin
      if (!rstn_in) begin
         master_out     <= 1'h0;
         start_done_out <= 1'h0;
      end else begin
         master_out     <= (state_nxt == ist_pkg::IST_HOLD) ||
                           (state_nxt == ist_pkg::IST_MAST);
         start_done_out <= start_fin;
      end
   end
endmodule
`default_nettype wire

// >>> ist_start_trigger_chk.sv
// Port checker for the start trigger block.
// Assumes it is bound to every instance and sees only the top ports.
`timescale 1ns/10ps
`default_nettype none
module ist_start_trigger_chk #(
   parameter int unsigned HOLD_CYC = 4,
   parameter int unsigned FREE_CYC = 4
) (
   // Clock and reset.
   input  wire logic core_clk_in,
   input  wire logic rstn_in,
   // Control inputs of the block.
   input  wire logic start_trigger_wr_in,
   input  wire logic start_trigger_val_in,
   input  wire logic bus_interface_enable_in,
   input  wire logic arb_lost_in,
   // Outputs under watch.
   input  wire logic serial_data_line_oe_out,
   input  wire logic serial_clock_line_oe_out,
   input  wire logic start_trigger_out,
   input  wire logic bus_busy_out,
   input  wire logic master_out,
   input  wire logic start_done_out
);
   // Stop seen to pending start, with slack for pin synchronisation.
   localparam int FREE_MAX = FREE_CYC + 16;
   // Every check runs on the core clock and rests during reset.
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (!rstn_in);

   // A data drive may only begin while the trigger was set.
   property p_no_idle_start;
      $rose(serial_data_line_oe_out) |-> $past(start_trigger_out);
   endproperty
   a_no_idle_start: assert property (p_no_idle_start)
      else $error("start without trigger");

   // A start makes the block master with the clock line still released.
   property p_start_shape;
      $rose(serial_data_line_oe_out) |-> master_out && !serial_clock_line_oe_out;
   endproperty
   a_start_shape: assert property (p_start_shape)
      else $error("bad start shape");

   // The clock line falls only after the data line has been held low.
   property p_start_hold;
      $rose(serial_clock_line_oe_out) |-> $past(serial_data_line_oe_out, HOLD_CYC);
   endproperty
   a_start_hold: assert property (p_start_hold)
      else $error("start hold too short");

   // A busy bus owned by someone else never sees a start from us.
   property p_busy_waits;
      bus_busy_out && !master_out |=> !$rose(serial_data_line_oe_out);
   endproperty
   a_busy_waits: assert property (p_busy_waits)
      else $error("start on busy bus");

   // A pending request turns into a start soon after the bus is released.
   property p_pending_go;
      $fell(bus_busy_out) && start_trigger_out && !master_out && bus_interface_enable_in
         |-> ##[1:FREE_MAX] $rose(serial_data_line_oe_out);
   endproperty
   a_pending_go: assert property (p_pending_go)
      else $error("pending start missing");

   // A software write stores its value on the next edge.
   property p_write_sets;
      start_trigger_wr_in |=> start_trigger_out == $past(start_trigger_val_in);
   endproperty
   a_write_sets: assert property (p_write_sets)
      else $error("write not stored");

   // Lost arbitration clears the trigger unless a write lands with it.
   property p_arb_clears;
      arb_lost_in && !start_trigger_wr_in |=> !start_trigger_out;
   endproperty
   a_arb_clears: assert property (p_arb_clears)
      else $error("trigger kept after loss");

   // A finished start clears the trigger in the same edge.
   property p_done_clears;
      start_done_out && !$past(start_trigger_wr_in) |-> !start_trigger_out;
   endproperty
   a_done_clears: assert property (p_done_clears)
      else $error("trigger kept after start");

   // A disabled interface drives no data line and is never master.
   property p_off_idle;
      !bus_interface_enable_in |=> !serial_data_line_oe_out && !master_out;
   endproperty
   a_off_idle: assert property (p_off_idle)
      else $error("active while disabled");
endmodule
bind ist_start_trigger ist_start_trigger_chk #(.HOLD_CYC(HOLD_CYC), .FREE_CYC(FREE_CYC))
   ist_start_trigger_chk_i (.core_clk_in, .rstn_in, .start_trigger_wr_in, .start_trigger_val_in,
   .bus_interface_enable_in, .arb_lost_in, .serial_data_line_oe_out, .serial_clock_line_oe_out,
   .start_trigger_out, .bus_busy_out, .master_out, .start_done_out);
`default_nettype wire

// >>> ist_start_trigger_tb_top.sv
// Bench for the start trigger block with a foreign master on the bus.
// Assumes hold and free counts of four cycles so the run stays short.
`timescale 1ns/10ps
`default_nettype none
module ist_start_trigger_tb_top;
   logic clk = 1'h0, rstn = 1'h0, wr = 1'h0, val = 1'h0, en = 1'h1, arb = 1'h0, rel = 1'h0;
   logic sda, scl, sda_oe, scl_oe, trig, busy, mast, done; // Wires and status.
   logic sdo, sco; // Pin levels that the block drives under its enables.
   localparam int HOLD_T = 4; // Short hold count keeps the run brief.
   localparam int FREE_T = 4; // Short free-time count keeps the run brief.
   int   err_count = 0, checks_done = 0, i; // Counters.
   always #2 clk = !clk; // The 250 MHz core clock.
   ist_bus_peer ist_bus_peer_i (.dev_sda_oe_in(sda_oe), .dev_scl_oe_in(scl_oe),
      .sda_out(sda), .scl_out(scl));
   ist_start_trigger #(.HOLD_CYC(HOLD_T), .FREE_CYC(FREE_T)) ist_start_trigger_i (
      .core_clk_in(clk), .rstn_in(rstn), .start_trigger_wr_in(wr), .start_trigger_val_in(val),
      .bus_interface_enable_in(en), .arb_lost_in(arb), .master_release_in(rel),
      .serial_data_line_in(sda), .serial_data_line_out(sdo), .serial_data_line_oe_out(sda_oe),
      .serial_clock_line_in(scl), .serial_clock_line_out(sco), .serial_clock_line_oe_out(scl_oe),
      .start_trigger_out(trig), .bus_busy_out(busy), .master_out(mast), .start_done_out(done));
   task automatic summarize();
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input logic got, input logic exp, input string what);
      checks_done++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH at %0t: %s", $time, what);
      end
   endtask
   // One-cycle software write, launched at a falling edge.
   task automatic write_trig(input logic v);
      @(negedge clk);
      wr = 1'h1;
      val = v;
      @(negedge clk);
      wr = 1'h0;
   endtask
   // Bounded wait: 0 data enable, 1 start done, 2 bus busy.
   task automatic wait_for(input int sel, input logic lvl);
      for (i = 0; i < 3000 && (sel == 0 ? sda_oe : sel == 1 ? done : busy) !== lvl; i++)
         @(negedge clk);
      if (i == 3000) begin
         err_count++;
         $display("MISMATCH at %0t: wait ran out", $time);
         summarize();
      end
   endtask
   initial begin
      repeat (10) @(negedge clk);
      rstn = 1'h1;
      repeat (30) @(negedge clk);
      chk(sda_oe, 1'h0, "start without trigger");
      chk(trig, 1'h0, "trigger reset value");
      $display("test idle done");
      write_trig(1'h1);
      chk(trig, 1'h1, "trigger not set");
      wait_for(0, 1'h1);
      chk(i == FREE_T + 1, 1'h1, "free time count wrong");
      chk(scl_oe, 1'h0, "clock pulled with data");
      chk(sdo, 1'h0, "data pin not driven low");
      chk(sco, 1'h0, "clock pin not driven low");
      chk(sda, 1'h0, "data not low");
      chk(scl, 1'h1, "clock not high");
      chk(mast, 1'h1, "not master");
      wait_for(1, 1'h1);
      chk(i == HOLD_T, 1'h1, "hold time count wrong");
      chk(scl_oe, 1'h1, "clock not pulled");
      chk(trig, 1'h0, "trigger kept after start");
      rel = 1'h1;
      @(negedge clk);
      rel = 1'h0;
      $display("test free start done");
      en = 1'h0;
      write_trig(1'h1);
      repeat (40) @(negedge clk);
      chk(sda_oe, 1'h0, "start while disabled");
      write_trig(1'h0);
      chk(trig, 1'h0, "write of zero ignored");
      en = 1'h1;
      $display("test disabled done");
      write_trig(1'h1);
      wait_for(0, 1'h1);
      en = 1'h0;
      @(negedge clk);
      chk(sda_oe, 1'h0, "data held after disable");
      chk(mast, 1'h0, "master after disable");
      repeat (10) @(negedge clk);
      chk(scl_oe, 1'h0, "clock pulled after disable");
      chk(trig, 1'h1, "trigger lost without a clear");
      write_trig(1'h0);
      en = 1'h1;
      $display("test disable during start done");
      fork
         ist_bus_peer_i.frame();
         begin
            wait_for(2, 1'h1);
            write_trig(1'h1);
            arb = 1'h1;
            @(negedge clk);
            arb = 1'h0;
            chk(trig, 1'h0, "trigger kept after loss");
         end
      join
      repeat (40) @(negedge clk);
      chk(sda_oe, 1'h0, "start after lost arbitration");
      $display("test arbitration done");
      fork
         ist_bus_peer_i.frame();
         begin
            wait_for(2, 1'h1);
            write_trig(1'h1);
            repeat (50) @(negedge clk);
            chk(sda_oe, 1'h0, "start on busy bus");
            chk(trig, 1'h1, "pending request lost");
         end
      join
      wait_for(0, 1'h1);
      chk(mast, 1'h1, "pending start missing");
      $display("test pending done");
      summarize();
   end
endmodule
`default_nettype wire

// >>> ist_sync.sv
// Two flip-flop synchroniser for one level from outside the clock domain.
// Assumes the input is a slowly changing pin level.
`timescale 1ns/10ps
`default_nettype none
module ist_sync (
   // Clock and reset.
   input  wire logic core_clk_in,
   input  wire logic rstn_in,
   // Asynchronous level and its synchronised copy.
   input  wire logic async_in,
   output logic      sync_out
);
   // First stage, read only by the second stage.
   logic meta_r;

   // Both stages reset to the idle high level of a pulled-up line.
   always_ff @(posedge core_clk_in) begin
      if (!rstn_in) begin
         meta_r   <= 1'h1;
         sync_out <= 1'h1;
      end else begin
         meta_r   <= async_in;
         sync_out <= meta_r;
      end
   end
endmodule
`default_nettype wire
